// [shared/adc_alarm_frame_pkg.sv]
/*
 * Shared constants and types for the converter alarm and frame block.
 * Assumes a 14-bit straight-binary converter core and a 16-bit
 * configuration word shifted in at the start of every frame.
 */
package adc_alarm_frame_pkg;

    // result and configuration widths
    localparam int RES_BITS = 14;
    localparam int CFG_BITS = 16;
    localparam int EDGE_W = 6;

    // channel select field inside the configuration word
    localparam int CHSEL_LSB = 0;

    // serial-clock falling edge numbers, counted from zero
    localparam logic [EDGE_W-1:0] LAST_CFG_EDGE = 6'h0f;
    localparam logic [EDGE_W-1:0] EDGE_SAT = 6'h3f;

    // code limits and hysteresis margins
    localparam logic [RES_BITS-1:0] CODE_MIN = 14'h0000;
    localparam logic [RES_BITS-1:0] CODE_MAX = 14'h3fff;
    localparam logic [RES_BITS-1:0] HI_CLR_MARGIN = 14'h0002;
    localparam logic [RES_BITS-1:0] LO_SET_MARGIN = 14'h0001;
    localparam logic [RES_BITS-1:0] LO_CLR_MARGIN = 14'h0001;

    // values after reset
    localparam logic [CFG_BITS-1:0] CFG_RESET = 16'h0000;
    localparam logic [RES_BITS-1:0] RESULT_RESET = 14'h0000;

    typedef logic [RES_BITS-1:0] code_t;

    // per-channel alarm programming
    typedef struct packed {
        code_t hiThresh;
        code_t hiHyst;
        code_t loThresh;
        code_t loHyst;
    } alarmCfg_t;

    // one flag for the high alarm, one for the low alarm
    typedef struct packed {
        logic hi;
        logic lo;
    } alarmPair_t;

    typedef enum logic {
        FRAME_IDLE,
        FRAME_BUSY
    } frameState_t;

endpackage : adc_alarm_frame_pkg

// [rtl/adc_alarm_frame.sv]
/*
 * Frame engine, output shifter and per-channel threshold alarms of a
 * multichannel 14-bit converter. The serial pins come from a host in
 * another clock domain and are sampled on clk_sys; the converter core
 * runs on clk_sys and returns a code with a one-cycle done strobe.
 */
// Summary of operation
// (RULE1) results are unsigned straight binary, same format on all channels
// (RULE2) results are 14-bit codes, one step is span over 16384
// (RULE3) negative full scale maps to zero, positive full scale to top code
// (RULE4) alarm pin is high-active and changes only on 16th falling edge
// (RULE5) alarm pin is high while any tripped flag is set
// (RULE6) host reads flag registers after an alarm to find the channel
// (RULE7) each channel has own high and low thresholds and hysteresis
// (RULE8) high alarm sets when code exceeds threshold plus hysteresis
// (RULE9) high alarm clears at or below threshold minus hysteresis minus 2
// (RULE10) low alarm sets below threshold minus hysteresis minus 1
// (RULE11) low alarm clears at or above threshold plus hysteresis plus 1
// (RULE12) active flag follows the alarm condition
// (RULE13) tripped flag sets like active, cleared only by flag read
// (RULE14) chip-select fall starts frame, samples channel, starts conversion
// (RULE15) converted channel is the one chosen in the previous frame
// (RULE16) next settings shift in while the conversion runs
// (RULE17) converter stays idle while chip select is high
// (RULE18) inputs are sampled on serial-clock falling edges
// (RULE19) sixteen falling edges after chip-select fall form config word
// (RULE20) a new configuration applies at the next chip-select fall
// (RULE21) data out low for 15 edges, msb on 16th, one bit per edge
// (RULE22) zeros after the 14 bits, released when chip select rises
// (RULE23) comparisons are unsigned 14-bit, done once per frame at edge 16
// (RULE24) threshold limits saturate at lowest and highest code
`timescale 1ns/1ps

module adc_alarm_frame
    import adc_alarm_frame_pkg::*;
#(
    parameter int NCH = 8
)
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    // serial pins from the host
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdoOe,
    output logic alarm,
    // alarm programming and flag access
    input wire alarmCfg_t alarmCfg [NCH],
    input wire logic flagRead,
    output alarmPair_t [NCH-1:0] activeFlag,
    output alarmPair_t [NCH-1:0] trippedFlag,
    // converter core
    output logic convStart,
    output logic [$clog2(NCH)-1:0] convChan,
    input wire logic convDone,
    input wire code_t convCode,
    // configuration in force this frame
    output logic [CFG_BITS-1:0] cfgWord
);

    localparam int CW = $clog2(NCH);

    // saturating unsigned add, never wraps past the top code
    function automatic code_t satAdd(input code_t a, input code_t b);
        logic [RES_BITS:0] s;
        s = {1'b0, a} + {1'b0, b};
        satAdd = s[RES_BITS] ? CODE_MAX : s[RES_BITS-1:0]; // [RULE24]
    endfunction : satAdd

    // saturating unsigned subtract, never wraps below zero
    function automatic code_t satSub(input code_t a, input code_t b);
        satSub = (a < b) ? CODE_MIN : code_t'(a - b); // [RULE24]
    endfunction : satSub

    // reset release through two flops
    logic [1:0] rstPipe_q;
    logic rstN;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rstPipe_q <= 2'h0;
        else
            rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
    assign rstN = rstPipe_q[1];

    // pin synchronisers, third stage only for edge finding
    logic [2:0] csS_q, csS_d;
    logic [2:0] sclkS_q, sclkS_d;
    logic [1:0] sdiS_q, sdiS_d;
    logic csFall, csRise, sclkFall, sdiBit;

    always_comb
    begin
        csS_d = {csS_q[1:0], csN};
        sclkS_d = {sclkS_q[1:0], sclk};
        sdiS_d = {sdiS_q[0], sdi};
    end

    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            csS_q <= 3'h7;
            sclkS_q <= 3'h7;
            sdiS_q <= 2'h0;
        end
        else if (clkEn)
        begin
            csS_q <= csS_d;
            sclkS_q <= sclkS_d;
            sdiS_q <= sdiS_d;
        end
    end

    // edges seen only from stages two and three
    assign csFall = csS_q[2] & ~csS_q[1];
    assign csRise = ~csS_q[2] & csS_q[1];
    assign sclkFall = sclkS_q[2] & ~sclkS_q[1]; // [RULE18]
    // data shares sclk's latency, so it lines up with the edge
    assign sdiBit = sdiS_q[1];

    // frame, shifter and alarm state
    frameState_t state_q, state_d;
    logic [EDGE_W-1:0] edge_q, edge_d;
    logic [CFG_BITS-1:0] shiftIn_q, shiftIn_d;
    logic [CFG_BITS-1:0] pendCfg_q, pendCfg_d;
    logic [CFG_BITS-1:0] cfgWord_d;
    code_t result_q, result_d;
    code_t outShift_q, outShift_d;
    logic [CW-1:0] convChan_d;
    logic convStart_d, sdo_d, sdoOe_d, alarm_d;
    alarmPair_t [NCH-1:0] active_d, tripped_d;

    // next-state logic for the whole frame
    always_comb
    begin
        code_t code;
        alarmCfg_t c;
        code_t hiUp, hiDn, loDn, loUp;
        alarmPair_t act;
        code = result_q;
        c = alarmCfg[convChan];
        act = activeFlag[convChan];
        hiUp = satAdd(c.hiThresh, c.hiHyst);
        hiDn = satSub(c.hiThresh, satAdd(c.hiHyst, HI_CLR_MARGIN));
        loDn = satSub(c.loThresh, satAdd(c.loHyst, LO_SET_MARGIN));
        loUp = satAdd(satAdd(c.loThresh, c.loHyst), LO_CLR_MARGIN);

        state_d = state_q;
        edge_d = edge_q;
        shiftIn_d = shiftIn_q;
        pendCfg_d = pendCfg_q;
        cfgWord_d = cfgWord;
        outShift_d = outShift_q;
        convChan_d = convChan;
        convStart_d = 1'b0;
        sdo_d = sdo;
        sdoOe_d = sdoOe;
        alarm_d = alarm;
        active_d = activeFlag;
        tripped_d = trippedFlag;
        result_d = result_q;

        // code taken as is: unsigned straight binary, 14 bits
        if (convDone)
            result_d = convCode; // [RULE1] [RULE2] [RULE3]

        // a flag read clears tripped flags; a new set below wins
        if (flagRead)
            tripped_d = '0; // [RULE13]

        if (csFall)
        begin
            // new frame: apply last frame's word and start converting
            state_d = FRAME_BUSY;
            edge_d = '0;
            cfgWord_d = pendCfg_q; // [RULE20]
            convChan_d = pendCfg_q[CHSEL_LSB +: CW]; // [RULE15]
            convStart_d = 1'b1; // [RULE14]
            sdoOe_d = 1'b1; // [RULE21]
            sdo_d = 1'b0;
        end
        else if (csRise)
        begin
            // idle until the next fall; an unfinished word is dropped
            state_d = FRAME_IDLE; // [RULE17]
            sdoOe_d = 1'b0; // [RULE22]
            sdo_d = 1'b0;
        end
        else if (state_q == FRAME_BUSY && sclkFall)
        begin
            if (edge_q != EDGE_SAT)
                edge_d = edge_q + 6'h01;
            if (edge_q <= LAST_CFG_EDGE)
            begin
                // settings shift in while the core converts
                shiftIn_d = {shiftIn_q[CFG_BITS-2:0], sdiBit}; // [RULE19]
                sdo_d = 1'b0; // [RULE21]
            end
            if (edge_q == LAST_CFG_EDGE)
            begin
                // held until the next chip-select fall
                pendCfg_d = shiftIn_d; // [RULE16] [RULE20]
                sdo_d = code[RES_BITS-1]; // [RULE21]
                outShift_d = {code[RES_BITS-2:0], 1'b0};
                // high alarm with hysteresis, unsigned compares
                if (!act.hi && code > hiUp)
                    act.hi = 1'b1; // [RULE8] [RULE23]
                else if (act.hi && code <= hiDn)
                    act.hi = 1'b0; // [RULE9]
                // low alarm with hysteresis
                if (!act.lo && code < loDn)
                    act.lo = 1'b1; // [RULE10] [RULE23]
                else if (act.lo && code >= loUp)
                    act.lo = 1'b0; // [RULE11]
                active_d[convChan] = act; // [RULE7] [RULE12]
                tripped_d[convChan].hi = tripped_d[convChan].hi | act.hi;
                tripped_d[convChan].lo = tripped_d[convChan].lo | act.lo;
                // pin only moves here, on the 16th edge
                alarm_d = |tripped_d; // [RULE4] [RULE5]
            end
            else if (edge_q > LAST_CFG_EDGE)
            begin
                // zeros shift in behind the lsb until the frame ends
                sdo_d = outShift_q[RES_BITS-1]; // [RULE21] [RULE22]
                outShift_d = {outShift_q[RES_BITS-2:0], 1'b0};
            end
        end
    end

    // frame registers
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            state_q <= FRAME_IDLE;
            edge_q <= '0;
            shiftIn_q <= CFG_RESET;
            pendCfg_q <= CFG_RESET;
            cfgWord <= CFG_RESET;
            result_q <= RESULT_RESET;
            outShift_q <= RESULT_RESET;
            convChan <= '0;
            convStart <= 1'b0;
            sdo <= 1'b0;
            sdoOe <= 1'b0;
            alarm <= 1'b0;
            activeFlag <= '0;
            trippedFlag <= '0;
        end
        else if (clkEn)
        begin
            state_q <= state_d;
            edge_q <= edge_d;
            shiftIn_q <= shiftIn_d;
            pendCfg_q <= pendCfg_d;
            cfgWord <= cfgWord_d;
            result_q <= result_d;
            outShift_q <= outShift_d;
            convChan <= convChan_d;
            convStart <= convStart_d;
            sdo <= sdo_d;
            sdoOe <= sdoOe_d;
            alarm <= alarm_d;
            activeFlag <= active_d;
            trippedFlag <= tripped_d;
        end
    end

endmodule : adc_alarm_frame

// [test/adc_alarm_frame_properties.sv]
/* port assertions for adc_alarm_frame.
   assumes it is bound into that module and sees its ports by name. */
`timescale 1ns/1ps
module adc_alarm_frame_properties
    import adc_alarm_frame_pkg::*;
#(
    parameter int NCH = 8
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // watched pins and status
    input wire logic csN,
    input wire logic sdo,
    input wire logic sdoOe,
    input wire logic alarm,
    input wire logic flagRead,
    input wire alarmPair_t [NCH-1:0] trippedFlag,
    input wire logic convStart,
    input wire logic [$clog2(NCH)-1:0] convChan,
    input wire logic [CFG_BITS-1:0] cfgWord
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // frame end as the pin shows it; sync delay allows some slack
    sequence csRelease;
        $rose(csN);
    endsequence
    a_alarm_in_frame: assert property ($changed(alarm) |-> sdoOe)
        else $error("alarm moved outside a frame");
    a_alarm_has_trip: assert property ($rose(alarm) |-> (|trippedFlag))
        else $error("alarm rose with no tripped flag");
    a_start_opens_oe: assert property ($rose(sdoOe) |-> convStart)
        else $error("output enabled without conversion start");
    a_start_one_pulse: assert property (convStart |=> !convStart)
        else $error("conversion start longer than one cycle");
    a_idle_no_start: assert property (csN [*5] |-> !convStart)
        else $error("conversion started while deselected");
    a_oe_release: assert property (csRelease |-> ##[2:6] !sdoOe)
        else $error("data out not released after deselect");
    a_sdo_low_idle: assert property (!sdoOe |-> !sdo)
        else $error("data out high while released");
    a_chan_from_cfg: assert property (convStart |->
        (convChan == cfgWord[$clog2(NCH)-1:0]))
        else $error("converted channel differs from applied word");
    a_cfg_held: assert property (!convStart |-> $stable(cfgWord))
        else $error("configuration changed outside frame start");
    a_trip_latched: assert property (!flagRead |=>
        ((~trippedFlag & $past(trippedFlag)) == '0))
        else $error("tripped flag cleared without a read");
endmodule : adc_alarm_frame_properties

// [test/serial_host_model.sv]
/* behavioural serial master standing in for the host controller.
   assumes the device samples on sclk falls; sclk rests high between
   frames, and the bench keeps csN high long enough between calls. */
`timescale 1ns/1ps
module serial_host_model
(
    // pins toward the device
    output logic csN,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdoOe
);
    // idle pins before the first frame
    initial
    begin
        csN = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
    end
    // one 32-edge frame; x read back if the pin was not driven
    task automatic frame(input logic [15:0] word, output logic [31:0] rx);
        csN = 1'b0;
        for (int k = 0; k < 32; k++)
        begin
            // word shifts in during conversion; later sdi is junk
            sdi = (k < 16) ? word[15 - k] : ~sdi;
            #32 rx = {rx[30:0], (sdoOe === 1'b1) ? sdo : 1'bx};
            sclk = 1'b0;
            #32 sclk = 1'b1;
        end
        #32 csN = 1'b1;
    endtask : frame
endmodule : serial_host_model

// [test/test_adc_alarm_frame.sv]
/* self-checking bench: host model frames, converter stand-in, checks.
   assumes NCH of 8 and a core that answers 20 cycles after start. */
`timescale 1ns/1ps
module test_adc_alarm_frame;
    import adc_alarm_frame_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clkEn = 1'b1;
    logic csN, sclk, sdi, sdo, sdoOe, alarm, flagRead, convStart, convDone;
    alarmCfg_t alarmCfg [8];
    alarmPair_t [7:0] activeFlag;
    alarmPair_t [7:0] trippedFlag;
    logic [2:0] convChan;
    code_t convCode, curCode;
    logic [15:0] cfgWord, word, prevWord;
    logic [31:0] rx;
    int n_errors = 0;
    int total_checks = 0;
    // per frame: code, converted channel, {active, tripped, alarm} of ch 2
    code_t codeTab [10] = '{14'h004b, 14'h0069, 14'h006a, 14'h005e,
        14'h005d, 14'h002e, 14'h002d, 14'h0035, 14'h0036, 14'h3fff};
    logic [2:0] chanTab [11] = '{3'h0, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2,
        3'h2, 3'h2, 3'h2, 3'h5, 3'h0};
    logic [4:0] expTab [10] = '{5'h00, 5'h00, 5'h15, 5'h15, 5'h05,
        5'h00, 5'h0b, 5'h0b, 5'h03, 5'h03};

    always #2.5 clk_sys = ~clk_sys;

    adc_alarm_frame uut (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
        .csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe),
        .alarm(alarm), .alarmCfg(alarmCfg), .flagRead(flagRead),
        .activeFlag(activeFlag), .trippedFlag(trippedFlag),
        .convStart(convStart), .convChan(convChan), .convDone(convDone),
        .convCode(convCode), .cfgWord(cfgWord));
    serial_host_model host (.csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdoOe(sdoOe));

    // converter stand-in; done well before the 16th fall
    always @(posedge clk_sys)
    begin
        if (convStart === 1'b1)
        begin
            repeat (20) @(posedge clk_sys);
            #1 convDone = 1'b1;
            convCode = curCode;
            @(posedge clk_sys);
            #1 convDone = 1'b0;
        end
    end

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // watchdog well beyond ten frames of about 2.1 us
    initial
    begin
        #100000;
        n_errors++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        flagRead = 1'b0;
        convDone = 1'b0;
        convCode = '0;
        curCode = '0;
        prevWord = CFG_RESET;
        // big hysteresis elsewhere: a wrapping limit would raise alarms
        for (int c = 0; c < 8; c++)
            alarmCfg[c] = '{14'h3fff, 14'h0010, 14'h0000, 14'h0010};
        alarmCfg[2] = '{14'h0064, 14'h0005, 14'h0032, 14'h0003};
        repeat (5) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (8) @(posedge clk_sys);
        for (int i = 0; i < 10; i++)
        begin
            #1 curCode = codeTab[i];
            word = {4'hc, i[8:0], chanTab[i + 1]};
            host.frame(word, rx);
            repeat (8) @(posedge clk_sys);
            check(rx, {16'h0000, codeTab[i], 2'b00});
            check(convChan, chanTab[i]);
            check(cfgWord, prevWord);
            check({activeFlag, trippedFlag, alarm}, {10'h0, expTab[i][4:3],
                14'h0, expTab[i][2:1], 4'h0, expTab[i][0]});
            prevWord = word;
            if (i == 4)
            begin
                // enable low: the read must not clear anything yet
                #1 clkEn = 1'b0;
                flagRead = 1'b1;
                @(posedge clk_sys);
                @(posedge clk_sys);
                check({trippedFlag, alarm}, 17'h00041);
                #1 clkEn = 1'b1;
                @(posedge clk_sys);
                #1 flagRead = 1'b0;
                @(posedge clk_sys);
                check({trippedFlag, alarm}, 17'h00001);
            end
        end
        give_verdict();
    end
endmodule : test_adc_alarm_frame

bind adc_alarm_frame adc_alarm_frame_properties #(.NCH(NCH)) chk (
    .clk_sys(clk_sys), .resetn(resetn), .csN(csN), .sdo(sdo),
    .sdoOe(sdoOe), .alarm(alarm), .flagRead(flagRead),
    .trippedFlag(trippedFlag), .convStart(convStart),
    .convChan(convChan), .cfgWord(cfgWord));
